/* sent_frame_pkg.sv */
// Constants and types for the nibble frame transmitter with diagnostics
`default_nettype none
package sent_frame_pkg;
   // Clock and self-test timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned LOGIC_SELF_TEST_MS = 10;
   localparam int unsigned LOGIC_SELF_TEST_CYC = CLK_HZ / 1000 * LOGIC_SELF_TEST_MS;
   // Tick counts of the frame symbols and index of the last nibble
   localparam logic [9:0] LOW_TICKS = 10'h005;
   localparam logic [9:0] NIB_BASE = 10'h00c;
   localparam logic [9:0] SYNC_TICKS = 10'h038;
   localparam logic [9:0] FRAME_TICKS = 10'h11c;
   localparam logic [2:0] LAST_NIB3 = 3'h4;
   localparam logic [2:0] LAST_NIB6 = 3'h7;
   // Check nibble: x^4+x^3+x^2+1, seed 0101
   localparam logic [3:0] CRC_POLY = 4'hd;
   localparam logic [3:0] CRC_SEED = 4'h5;
   // Nonvolatile word offsets
   localparam logic [7:0] ADR_FRAME = 8'h17;
   localparam logic [7:0] ADR_CFG1 = 8'h18;
   localparam logic [7:0] ADR_CFG2 = 8'h19;
   localparam logic [7:0] ADR_MASK = 8'h1e;
   localparam logic [7:0] ADR_SCR = 8'h1f;
   // Field positions in the frame word
   localparam int TICK_LSB = 3;
   localparam int TICK_MSB = 8;
   localparam int DMODE_BIT = 12;
   localparam int SC_LSB = 16;
   localparam int SC_MSB = 17;
   localparam int PAUSE_BIT = 20;
   // Field positions in the customer words
   localparam int THR_MSB = 10;
   localparam int OFS_MSB = 11;
   localparam int POL_BIT = 12;
   localparam int MSK_HALL = 10;
   localparam int MSK_LOGIC_SELF_TEST = 11;
   // Error word bit positions
   localparam int E_SUPPLY_LOSS_FLAG = 0;
   localparam int E_MISSING_FIELD_FLAG = 1;
   localparam int E_INTERNAL_FAULT_FLAG = 2;
   localparam int E_TMP = 4;
   localparam int E_EEP1 = 5;
   localparam int E_EEP2 = 6;
   localparam int E2_HALL = 3;
   localparam int E2_LOGIC_SELF_TEST = 4;
   localparam logic [6:0] ERR1_RST = 7'h01;
   // Synchroniser lanes
   localparam int S_HOT = 0;
   localparam int S_LOST = 1;
   localparam int S_UV = 2;
   // Hall ring self-test
   localparam int RING_N = 32;
   localparam logic [4:0] RING_LAST = 5'h1f;
   localparam logic [11:0] HALL_TOL = 12'h040;
   localparam int RING_SHIFT = 7;

   typedef enum logic [2:0] {F_SYNC = 3'b001, F_NIB = 3'b010, F_PAUSE = 3'b100} frame_e;
   typedef enum logic [2:0] {T_IDLE = 3'b001, T_LOGIC_SELF_TEST = 3'b010, T_HALL = 3'b100} test_e;

   typedef struct packed {
      logic [23:0] frame;
      logic [23:0] cfg1;
      logic [23:0] cfg2;
      logic [23:0] mask;
      logic [23:0] scr;
   } cfg_s;

   typedef struct packed {
      frame_e frame_st;
      test_e test_st;
      logic [7:0] pre;
      logic [9:0] tcnt;
      logic [9:0] fcnt;
      logic [9:0] plen;
      logic [2:0] nidx;
      logic [23:0] pay;
      logic [3:0] stat;
      logic [3:0] crc;
      logic six;
      logic [3:0] ser_idx;
      logic line;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [6:0] err1;
      logic lb_fail;
      logic hall_fail;
      cfg_s cfg;
      logic [23:0] rdata;
      logic [19:0] lbc;
      logic [4:0] ridx;
      logic [RING_N-1:0][11:0] ring;
   } state_s;
endpackage
`default_nettype wire

/* sent_frame_transmitter_diag.sv */
// Nibble frame transmitter with diagnostic flags and configuration words
`timescale 1ns/1ps
`default_nettype none
module sent_frame_transmitter_diag
   import sent_frame_pkg::*;
#(
   parameter int unsigned LOGIC_SELF_TEST_CYCLES = LOGIC_SELF_TEST_CYC
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [11:0] angle_i,
   input wire logic [10:0] field_i,
   input wire logic ecc_single_i,
   input wire logic ecc_double_i,
   input wire logic logic_fault_i,
   input wire logic hot_i,
   input wire logic lost_i,
   input wire logic uv_i,
   input wire logic err_clear_i,
   input wire logic logic_self_test_req_i,
   input wire logic logic_self_test_fail_i,
   input wire logic hall_req_spi_i,
   input wire logic hall_req_sent_i,
   input wire logic meas_valid_i,
   input wire logic nv_wr_i,
   input wire logic [7:0] nv_addr_i,
   input wire logic [23:0] nv_wdata_i,
   input wire logic [4:0] ring_idx_i,
   output logic sent_o,
   output logic [23:0] nv_rdata_o,
   output logic [12:0] err1_o,
   output logic [12:0] second_error_flags_word_o,
   output logic err_flag_o,
   output logic low_supply_o,
   output logic logic_self_test_run_o,
   output logic bias_en_o,
   output logic [4:0] bias_idx_o,
   output logic [11:0] ring_angle_o,
   output logic [11:0] angle_o
);
   localparam state_s RST = '{frame_st: F_PAUSE, test_st: T_IDLE, plen: NIB_BASE,
                              err1: ERR1_RST, default: '0};
   localparam logic [19:0] LB_LAST = 20'(LOGIC_SELF_TEST_CYCLES - 1);

   state_s q;
   state_s d;
   logic tick;
   logic sym_end;
   logic [9:0] sym_len;
   logic [3:0] cur_nib;
   logic [2:0] last_nib;
   logic [11:0] amap;
   logic [23:0] new_pay;
   logic [3:0] new_stat;
   logic err_any;
   logic [11:0] hdiff;

   // Augmented 4-bit checksum over three or six data nibbles
   function automatic logic [3:0] crc_calc(input logic [23:0] p, input logic six);
      logic [3:0] c;
      logic [23:0] sh;
      logic fb;
      int nd;
      begin
         c = CRC_SEED;
         sh = p;
         nd = six ? 6 : 3;
         for (int i = 0; i <= 6; i++)
         begin
            if (i <= nd)
            begin
               for (int k = 0; k < 4; k++)
               begin
                  fb = c[3];
                  c = {c[2:0], 1'b0};
                  if (fb)
                     c = c ^ CRC_POLY;
               end
               c = c ^ ((i < nd) ? sh[23:20] : 4'h0);
               sh = sh << 4;
            end
         end
         return c;
      end
   endfunction

   // Angle inverted by the direction bit and offset, wrapping in the 12-bit range
   assign amap = (q.cfg.cfg2[POL_BIT] ? ~angle_i : angle_i) + q.cfg.cfg2[OFS_MSB:0];
   // Unmasked flags reach the serial error flag
   assign err_any = |(q.err1 & ~q.cfg.mask[6:0])
                  | (q.lb_fail & ~q.cfg.mask[MSK_LOGIC_SELF_TEST])
                  | (q.hall_fail & ~q.cfg.mask[MSK_HALL]);
   // Snapshot for the next frame: angle, complement and status
   assign new_pay = {amap, ~amap};
   assign new_stat = {(q.cfg.frame[SC_MSB:SC_LSB] != 2'h0) && (q.ser_idx == 4'h0),
                      (q.cfg.frame[SC_MSB:SC_LSB] != 2'h0) && q.cfg.scr[q.ser_idx],
                      q.test_st == T_HALL, err_any};
   // Tick prescaler from the tick-period field
   // Greater-or-equal so that a shorter tick written mid-count does not wrap the prescaler
   assign tick = (q.pre >= {2'h0, q.cfg.frame[TICK_MSB:TICK_LSB]});
   assign last_nib = q.six ? LAST_NIB6 : LAST_NIB3;
   // Distance of the new element angle from its nominal ring position
   assign hdiff = angle_i - {q.ridx, 7'h00};

   // Nibble value and symbol length in ticks
   always_comb
   begin
      cur_nib = q.crc;
      if (q.nidx == 3'h0)
         cur_nib = q.stat;
      else if (q.nidx != last_nib)
         cur_nib = 4'(q.pay >> (5'd24 - {q.nidx, 2'b00}));
      case (q.frame_st)
         F_SYNC: sym_len = SYNC_TICKS;
         F_NIB: sym_len = NIB_BASE + {6'h0, cur_nib};
         F_PAUSE: sym_len = q.plen;
         default: sym_len = SYNC_TICKS;
      endcase
   end
   assign sym_end = tick && (q.tcnt == sym_len - 10'h001);

   // Next state of the whole block
   always_comb
   begin
      d = q;
      d.sync1 = {uv_i, lost_i, hot_i};
      d.sync2 = q.sync1;
      d.pre = tick ? 8'h00 : q.pre + 8'h01;
      // Configuration word access
      if (nv_wr_i)
      begin
         case (nv_addr_i)
            ADR_FRAME: d.cfg.frame = nv_wdata_i;
            ADR_CFG1: d.cfg.cfg1 = nv_wdata_i;
            ADR_CFG2: d.cfg.cfg2 = nv_wdata_i;
            ADR_MASK: d.cfg.mask = nv_wdata_i;
            ADR_SCR: d.cfg.scr = nv_wdata_i;
            default: d.cfg = q.cfg;
         endcase
      end
      case (nv_addr_i)
         ADR_FRAME: d.rdata = q.cfg.frame;
         ADR_CFG1: d.rdata = q.cfg.cfg1;
         ADR_CFG2: d.rdata = q.cfg.cfg2;
         ADR_MASK: d.rdata = q.cfg.mask;
         ADR_SCR: d.rdata = q.cfg.scr;
         default: d.rdata = 24'h000000;
      endcase
      // Frame sequencing, one symbol after another
      if (tick)
      begin
         d.tcnt = q.tcnt + 10'h001;
         d.fcnt = q.fcnt + 10'h001;
      end
      if (sym_end)
      begin
         d.tcnt = 10'h000;
         case (q.frame_st)
            F_SYNC:
            begin
               d.frame_st = F_NIB;
               d.nidx = 3'h0;
            end
            F_NIB:
            begin
               if (q.nidx != last_nib)
                  d.nidx = q.nidx + 3'h1;
               else if (q.cfg.frame[PAUSE_BIT])
               begin
                  d.frame_st = F_PAUSE;
                  d.plen = FRAME_TICKS - d.fcnt;
               end
               else
                  d.frame_st = F_SYNC;
            end
            F_PAUSE: d.frame_st = F_SYNC;
            default: d.frame_st = F_SYNC;
         endcase
         if (d.frame_st == F_SYNC)
         begin
            d.fcnt = 10'h000;
            d.pay = new_pay;
            d.stat = new_stat;
            d.six = q.cfg.frame[DMODE_BIT];
            d.crc = crc_calc(new_pay, q.cfg.frame[DMODE_BIT]);
            d.ser_idx = q.ser_idx + 4'h1;
         end
      end
      // Low for the first five ticks of each symbol, then high
      d.line = (d.tcnt >= LOW_TICKS);
      // Sticky error flags, a new event wins over the clear
      if (err_clear_i)
      begin
         d.err1 = 7'h00;
         d.lb_fail = 1'b0;
         d.hall_fail = 1'b0;
      end
      d.err1[E_EEP2] = d.err1[E_EEP2] | ecc_double_i;
      d.err1[E_EEP1] = d.err1[E_EEP1] | ecc_single_i;
      d.err1[E_TMP] = d.err1[E_TMP] | q.sync2[S_HOT];
      d.err1[E_INTERNAL_FAULT_FLAG] = d.err1[E_INTERNAL_FAULT_FLAG] | logic_fault_i;
      d.err1[E_MISSING_FIELD_FLAG] = d.err1[E_MISSING_FIELD_FLAG] | (field_i < q.cfg.cfg1[THR_MSB:0]);
      d.err1[E_SUPPLY_LOSS_FLAG] = d.err1[E_SUPPLY_LOSS_FLAG] | q.sync2[S_LOST];
      // Self-test sequencer
      case (q.test_st)
         T_IDLE:
         begin
            d.lbc = 20'h00000;
            d.ridx = 5'h00;
            if (logic_self_test_req_i)
               d.test_st = T_LOGIC_SELF_TEST;
            else if (hall_req_spi_i || hall_req_sent_i)
               d.test_st = T_HALL;
         end
         T_LOGIC_SELF_TEST:
         begin
            d.lbc = q.lbc + 20'h00001;
            if (q.lbc == LB_LAST)
            begin
               d.test_st = T_IDLE;
               d.lb_fail = d.lb_fail | logic_self_test_fail_i;
            end
         end
         T_HALL:
         begin
            if (meas_valid_i)
            begin
               d.ring[q.ridx] = angle_i;
               d.ridx = q.ridx + 5'h01;
               if (q.ridx == RING_LAST)
                  d.test_st = T_IDLE;
               if ((hdiff > HALL_TOL) && (hdiff < -HALL_TOL))
                  d.hall_fail = 1'b1;
            end
         end
         default: d.test_st = T_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         q <= RST;
      else
         q <= d;
   end

   // Outputs from the state register and, for angle_o, from the mapped angle input
   assign sent_o = q.line;
   assign nv_rdata_o = q.rdata;
   assign err1_o = {6'h00, q.err1};
   assign second_error_flags_word_o = {8'h00, q.lb_fail, q.hall_fail, 3'h0};
   assign err_flag_o = err_any;
   assign low_supply_o = q.sync2[S_UV];
   assign logic_self_test_run_o = (q.test_st == T_LOGIC_SELF_TEST);
   assign bias_en_o = (q.test_st == T_HALL);
   assign bias_idx_o = q.ridx;
   assign ring_angle_o = q.ring[ring_idx_i];
   assign angle_o = amap;

   // Helper counts for the checks: clocks low, ticks high
   logic [15:0] low_clk;
   logic [9:0] hi_tk;
   frame_e hi_sym;
   logic cfg_moved;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cfg_moved <= 1'b0;
         low_clk <= 16'h0000;
         hi_tk <= 10'h000;
         hi_sym <= F_PAUSE;
      end
      else
      begin
         low_clk <= sent_o ? 16'h0000 : low_clk + 16'h0001;
         // Frame word rewritten while the line is low: tick length not fixed
         cfg_moved <= (sent_o ? 1'b0 : cfg_moved) | (d.cfg.frame != q.cfg.frame);
         if (!sent_o)
            hi_tk <= 10'h000;
         else if (tick)
            hi_tk <= hi_tk + 10'h001;
         if (!sent_o)
            hi_sym <= q.frame_st;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_nib_fall;
      $fell(sent_o) && (hi_sym == F_NIB);
   endsequence
   sequence s_sync_fall;
      $fell(sent_o) && (hi_sym == F_SYNC);
   endsequence

   a_low_width: assert property ($rose(sent_o) && !cfg_moved |->
      low_clk == 16'(5 * ({8'h0, q.cfg.frame[TICK_MSB:TICK_LSB]} + 16'h1)))
      else $error("low interval not five ticks");
   a_nib_high: assert property (s_nib_fall |-> hi_tk >= 10'd7 && hi_tk <= 10'd22)
      else $error("nibble high interval out of range");
   a_sync_high: assert property (s_sync_fall |-> hi_tk == 10'd51)
      else $error("sync high interval wrong");
   a_frame_order: assert property ($changed(q.frame_st) && q.frame_st == F_SYNC |->
      $past(q.frame_st) == F_PAUSE || $past(q.nidx) == $past(last_nib))
      else $error("frame started early");
   a_pause_opt: assert property ($changed(q.frame_st) && q.frame_st == F_PAUSE |->
      $past(q.cfg.frame[PAUSE_BIT]))
      else $error("pause without enable");
   a_err_sticky: assert property (!err_clear_i |=>
      (q.err1 & $past(q.err1)) == $past(q.err1))
      else $error("error flag dropped without clear");
   a_set_wins: assert property (ecc_double_i && err_clear_i |=> q.err1[E_EEP2])
      else $error("event lost during clear");
   a_uv_flag: assert property (uv_i ##1 uv_i |=> low_supply_o)
      else $error("low supply bit not raised");
   a_logic_self_test_time: assert property ($rose(logic_self_test_run_o) |-> logic_self_test_run_o[*8])
      else $error("self-test ended too soon");
   a_hall_store: assert property (bias_en_o && meas_valid_i |=>
      q.ring[$past(q.ridx)] == $past(angle_i))
      else $error("ring angle not stored");
   a_missing_field_flag_set: assert property (field_i < q.cfg.cfg1[THR_MSB:0] |=> q.err1[E_MISSING_FIELD_FLAG])
      else $error("missing field flag not set");
endmodule
`default_nettype wire

/* sent_rx_model.sv */
// Receiver model of the frame line: measures low part and whole length of each symbol
`timescale 1ns/1ps
`default_nettype none
module sent_rx_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic line_i,
   output logic sym_o,
   output logic [15:0] low_o,
   output logic [15:0] tot_o
);
   logic line_q;
   logic [15:0] cnt_q;

   // Count clocks per symbol; a falling edge closes one symbol and opens the next
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         line_q <= 1'b0;
         cnt_q <= 16'h0000;
         sym_o <= 1'b0;
         low_o <= 16'h0000;
         tot_o <= 16'h0000;
      end
      else
      begin
         line_q <= line_i;
         sym_o <= line_q & ~line_i;
         cnt_q <= (line_q & ~line_i) ? 16'h0001 : cnt_q + 16'h0001;
         if (line_q & ~line_i)
            tot_o <= cnt_q;
         if (~line_q & line_i)
            low_o <= cnt_q;
      end
   end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the nibble frame transmitter with diagnostics
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin miscompares++; $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
   import sent_frame_pkg::*;
   localparam int unsigned LB_N = 20;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [11:0] angle_i = 12'h000;
   logic [10:0] field_i = 11'h7ff;
   // Events: single, double, fault, hot, lost, undervoltage
   logic [5:0] ev = 6'h00;
   logic err_clear_i = 1'b0, logic_self_test_req_i = 1'b0, logic_self_test_fail_i = 1'b0, meas_valid_i = 1'b0;
   logic hall_req_spi_i = 1'b0, hall_req_sent_i = 1'b0, nv_wr_i = 1'b0;
   logic [7:0] nv_addr_i = 8'h00;
   logic [23:0] nv_wdata_i = 24'h000000;
   logic [4:0] ring_idx_i = 5'h00;
   logic sent_o, err_flag_o, low_supply_o, logic_self_test_run_o, bias_en_o, sym;
   logic [23:0] nv_rdata_o;
   logic [12:0] err1_o, second_error_flags_word_o;
   logic [4:0] bias_idx_o;
   logic [11:0] ring_angle_o, angle_o;
   logic [15:0] low_len, tot_len;
   int miscompares = 0;
   int checked = 0;

   // Free-running clock
   always #50 clk_i = ~clk_i;

   sent_frame_transmitter_diag #(.LOGIC_SELF_TEST_CYCLES(LB_N)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .angle_i(angle_i), .field_i(field_i), .ecc_single_i(ev[0]), .ecc_double_i(ev[1]),
      .logic_fault_i(ev[2]), .hot_i(ev[3]), .lost_i(ev[4]), .uv_i(ev[5]),
      .err_clear_i(err_clear_i), .logic_self_test_req_i(logic_self_test_req_i), .logic_self_test_fail_i(logic_self_test_fail_i),
      .hall_req_spi_i(hall_req_spi_i), .hall_req_sent_i(hall_req_sent_i),
      .meas_valid_i(meas_valid_i), .nv_wr_i(nv_wr_i), .nv_addr_i(nv_addr_i),
      .nv_wdata_i(nv_wdata_i), .ring_idx_i(ring_idx_i), .sent_o(sent_o),
      .nv_rdata_o(nv_rdata_o), .err1_o(err1_o), .second_error_flags_word_o(second_error_flags_word_o), .err_flag_o(err_flag_o),
      .low_supply_o(low_supply_o), .logic_self_test_run_o(logic_self_test_run_o), .bias_en_o(bias_en_o),
      .bias_idx_o(bias_idx_o), .ring_angle_o(ring_angle_o), .angle_o(angle_o));

   sent_rx_model rx_u (.clk_i(clk_i), .rst_i(rst_i), .line_i(sent_o), .sym_o(sym),
      .low_o(low_len), .tot_o(tot_len));

   // Shared helpers
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cyc(int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic nv_write(logic [7:0] a, logic [23:0] d);
      nv_addr_i <= a;
      nv_wdata_i <= d;
      nv_wr_i <= 1'b1;
      cyc(1);
      nv_wr_i <= 1'b0;
      cyc(1);
   endtask

   task automatic nv_read(logic [7:0] a, output logic [23:0] d);
      nv_addr_i <= a;
      cyc(2);
      d = nv_rdata_o;
   endtask

   task automatic pulse_clear();
      err_clear_i <= 1'b1;
      cyc(1);
      err_clear_i <= 1'b0;
      cyc(2);
   endtask

   // One step of the 4-bit frame check over a nibble
   function automatic logic [3:0] crc_step(logic [3:0] c, logic [3:0] n);
      logic [7:0] r;
      r = {c, 4'h0};
      for (int b = 7; b >= 4; b--)
         if (r[b])
            r = r ^ (8'h1d << (b - 4));
      return r[3:0] ^ n;
   endfunction

   task automatic next_sym(output logic [15:0] lo, output logic [15:0] to);
      int n;
      for (n = 0; n < 20000; n++)
      begin
         @(negedge clk_i);
         if (sym === 1'b1)
            break;
      end
      if (n == 20000)
      begin
         miscompares++;
         results();
      end
      lo = low_len;
      to = tot_len;
   endtask

   // Capture one frame from the next sync pulse and judge every symbol
   task automatic frame_chk(int tk, int nd, logic pz, logic [3:0] st, logic [11:0] ma);
      logic [15:0] lo, to;
      logic [3:0] c, ex;
      int sum;
      to = 16'h0000;
      for (int k = 0; k < 40 && to != 16'(56 * tk); k++)
         next_sym(lo, to);
      `CHK("sync len", 16'(56 * tk), to)
      `CHK("sync low", 16'(5 * tk), lo)
      sum = 56;
      c = 4'h5;
      for (int i = 0; i <= nd + 1 + int'(pz); i++)
      begin
         next_sym(lo, to);
         ex = crc_step(c, 4'h0);
         if (i == 0)
            ex = st;
         else if (i <= 3)
            ex = ma[15 - 4 * i -: 4];
         else if (i <= nd)
            ex = ~ma[27 - 4 * i -: 4];
         if (i >= 1 && i <= nd)
            c = crc_step(c, ex);
         `CHK("nibble low", 16'(5 * tk), lo)
         if (i <= nd + 1)
            `CHK("nibble len", 16'(tk * (12 + int'(ex))), to)
         sum += int'(to) / tk;
      end
      if (pz)
         `CHK("frame ticks", 284, sum)
      @(posedge clk_i);
   endtask

   // Scenarios
   task automatic reset_scn();
      repeat (8) @(posedge clk_i);
      `CHK("line in reset", 1'b0, sent_o)
      `CHK("err1 reset", 13'h001, err1_o)
      `CHK("second_error_flags_word reset", 13'h000, second_error_flags_word_o)
      rst_i <= 1'b0;
      cyc(1);
   endtask

   task automatic basic_frame_scn();
      angle_i <= 12'ha5c;
      frame_chk(1, 3, 1'b0, 4'h1, 12'ha5c);
   endtask

   task automatic reg_scn();
      logic [7:0] a [6] = '{ADR_FRAME, ADR_CFG1, ADR_CFG2, ADR_MASK, ADR_SCR, 8'h1a};
      logic [23:0] d;
      for (int k = 0; k < 6; k++)
      begin
         nv_read(a[k], d);
         `CHK("nv reset", 24'h000000, d)
         nv_write(a[k], 24'h5a5a50 | 24'(k));
      end
      for (int k = 0; k < 6; k++)
      begin
         nv_read(a[k], d);
         `CHK("nv word", (k < 5) ? (24'h5a5a50 | 24'(k)) : 24'h000000, d)
         nv_write(a[k], 24'h000000);
      end
   endtask

   task automatic err_scn();
      int pos [5] = '{E_EEP1, E_EEP2, E_INTERNAL_FAULT_FLAG, E_TMP, E_SUPPLY_LOSS_FLAG};
      logic [12:0] e;
      e = 13'h000;
      pulse_clear();
      `CHK("err1 cleared", e, err1_o)
      for (int k = 0; k < 5; k++)
      begin
         ev <= 6'(1 << k);
         cyc(1);
         ev <= 6'h00;
         cyc(5);
         e[pos[k]] = 1'b1;
         `CHK("err1 set", e, err1_o)
      end
      `CHK("err flag", 1'b1, err_flag_o)
      nv_write(ADR_MASK, 24'h00007f);
      cyc(1);
      `CHK("masked flag", 1'b0, err_flag_o)
      nv_write(ADR_MASK, 24'h000000);
      ev <= 6'h20;
      cyc(5);
      `CHK("low supply", 1'b1, low_supply_o)
      ev <= 6'h00;
      nv_write(ADR_CFG1, 24'h000100);
      field_i <= 11'h050;
      cyc(5);
      `CHK("low supply off", 1'b0, low_supply_o)
      `CHK("missing field", 1'b1, err1_o[E_MISSING_FIELD_FLAG])
      field_i <= 11'h7ff;
      cyc(2);
      pulse_clear();
      `CHK("err1 cleared", 13'h000, err1_o)
   endtask

   task automatic long_frame_scn();
      angle_i <= 12'h3c7;
      nv_write(ADR_CFG2, 24'h001010);
      `CHK("mapped angle", 12'hc48, angle_o)
      nv_write(ADR_FRAME, 24'h101010);
      frame_chk(3, 6, 1'b1, 4'h0, 12'hc48);
      nv_write(ADR_FRAME, 24'h000000);
      nv_write(ADR_CFG2, 24'h000000);
   endtask

   task automatic logic_self_test_scn(logic fail);
      int n;
      n = 0;
      logic_self_test_fail_i <= fail;
      logic_self_test_req_i <= 1'b1;
      cyc(1);
      logic_self_test_req_i <= 1'b0;
      for (int k = 0; k < 200; k++)
      begin
         @(negedge clk_i);
         n += int'(logic_self_test_run_o === 1'b1);
         if (n > 0 && logic_self_test_run_o === 1'b0)
            break;
      end
      @(posedge clk_i);
      `CHK("self-test cycles", LB_N, n)
      `CHK("self-test result", fail, second_error_flags_word_o[E2_LOGIC_SELF_TEST])
      pulse_clear();
   endtask

   task automatic hall_scn(logic by_link);
      hall_req_spi_i <= ~by_link;
      hall_req_sent_i <= by_link;
      cyc(1);
      hall_req_spi_i <= 1'b0;
      hall_req_sent_i <= 1'b0;
      for (int k = 0; k < 32; k++)
      begin
         cyc(1);
         `CHK("bias on", 1'b1, bias_en_o)
         `CHK("bias element", 5'(k), bias_idx_o)
         angle_i <= 12'(k * 128) ^ {11'h000, by_link};
         meas_valid_i <= 1'b1;
         cyc(1);
         meas_valid_i <= 1'b0;
      end
      cyc(2);
      `CHK("bias off", 1'b0, bias_en_o)
      `CHK("hall result", 1'b0, second_error_flags_word_o[E2_HALL])
      for (int k = 0; k < 32; k++)
      begin
         ring_idx_i <= 5'(k);
         cyc(2);
         `CHK("ring angle", 12'(k * 128) ^ {11'h000, by_link}, ring_angle_o)
      end
   endtask

   // Main sequence
   initial
   begin
      reset_scn();
      basic_frame_scn();
      reg_scn();
      err_scn();
      long_frame_scn();
      logic_self_test_scn(1'b1);
      logic_self_test_scn(1'b0);
      hall_scn(1'b0);
      hall_scn(1'b1);
      results();
   end
endmodule
`default_nettype wire
